// ---- inc/pfs_pkg.sv ----
// constants for the port E / port F pin function select block
// assumes a 16-bit register port with byte addresses on even boundaries
package pfs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int NUM_E_PINS = 14;
	localparam int NUM_F_PINS = 16;
	localparam int SYNC_STAGES = 3;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PE_DIR = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PE_UPPER = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_PE_LOWER = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_PE_ALT = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_PF_DIR = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_PF_UPPER = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_PF_LOWER = 4'hC;

	// writable bits of each register; everything else is reserved
	localparam logic [DATA_W-1:0] MASK_PE_DIR = 16'h3FFF;
	localparam logic [DATA_W-1:0] MASK_PE_UPPER = 16'h0555;
	localparam logic [DATA_W-1:0] MASK_PE_LOWER = 16'hF57D;
	localparam logic [DATA_W-1:0] MASK_PE_ALT = 16'h0FC0;
	localparam logic [DATA_W-1:0] MASK_PF_DIR = 16'hFFFF;
	localparam logic [DATA_W-1:0] MASK_PF_SEL = 16'hFFFF;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

	// field positions in the port E lower select register
	localparam int PE7_LSB = 14;
	localparam int PE6_LSB = 12;
	localparam int PE2_LSB = 4;
	localparam int PE1_LSB = 2;
	localparam int PE0_BIT = 0;
	// pins 5..3 use bit 2*n (primary) and field 2*n+1:2*n (alternate)
	localparam int PE_SINGLE_STEP = 2;
	// pins 13..8 use bit 2*(n-8) of the upper select register
	localparam int PE_UPPER_BASE = 8;

	// select codes
	localparam logic [1:0] CODE_PORT = 2'h0;
	localparam logic [1:0] CODE_A = 2'h1;
	localparam logic [1:0] CODE_B = 2'h2;
	localparam logic [1:0] CODE_C = 2'h3;

	localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;
endpackage

// ---- rtl/pfs_sync.sv ----
// pin input synchroniser, three sync flops plus one output filter flop per bit
// assumes inputs are asynchronous to clk; output changes only when stages 2 and 3 agree
`timescale 1ns/1ps
module pfs_sync #(
	parameter int WIDTH = 16
) (
	input logic clk,
	input logic nrst,
	input logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1, s2, s3;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("pfs_sync width must be at least one");
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end
		else
		begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a bit only moves once it has been stable for two samples
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			level <= '0;
		else
			level <= (s2 & s3) | (level & (s2 ^ s3));
	end
endmodule

// ---- rtl/pfs_pin_cell.sv ----
// one pin's output stage: port or peripheral drive, plus port read path
// assumes select decode and synchronised pin level arrive from the same clock
`timescale 1ns/1ps
module pfs_pin_cell (
	input logic clk,
	input logic nrst,
	input logic port_mode,
	input logic dir,
	input logic port_dout,
	input logic fn_oe,
	input logic fn_out,
	input logic pin_level,
	output logic pad_out,
	output logic pad_oe,
	output logic port_din
);
	// registered so the pad never sees decode glitches while software rewrites a field
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pad_oe <= 1'b0;
			pad_out <= 1'b0;
		end
		else if (port_mode)
		begin
			pad_oe <= dir;
			pad_out <= dir & port_dout;
		end
		else
		begin
			pad_oe <= fn_oe;
			pad_out <= fn_oe & fn_out;
		end
	end

	// reads zero while a peripheral owns the pin
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			port_din <= 1'b0;
		else
			port_din <= port_mode & pin_level;
	end
endmodule

// ---- rtl/pfs_pin_function_select.sv ----
// pin function select for ports E and F: registers, decode, pin routing
// assumes power-on, standby and watchdog resets are merged into NRST outside
// assumes the far-end peripherals run on CLK; pins are asynchronous
//
// Contract
// - all select and direction registers clear on reset and keep values in sleep
// - reserved bits read zero and ignore writes
// - port E pins 13..8: one bit each, 0 port, 1 timer output
// - port E pin 7: 00 port, 01 timer output, 10 CAN receive, 11 prohibited
// - port E pin 6: 00 port, 01 timer output, 10 CAN transmit, 11 prohibited
// - port E pins 5..3: one bit each, 1 selects a capture input
// - port E pin 2: port, capture input, or one of two bidirectional channels
// - port E pin 1: port, capture input, or one of two bidirectional channels
// - port E pin 0: 0 port, 1 capture input
// - port E pins 5..3 alternate field: port, timer output, timer input
// - alternate field only acts while the primary bit is zero
// - port F direction bit n: 0 input, 1 output for pin n
// - port F direction only matters while the pin is in port use
// - port F pin 15: port, compare output, CAN receive, serial receive
// - port F pin 14: port, compare output, CAN transmit, serial transmit
// - port F pins 13..0: 00 port, 01 compare output, 11 timer input
// - port E direction bits 13..0 set pin direction in port use only
`timescale 1ns/1ps
module pfs_pin_function_select (
	input logic CLK,
	input logic NRST,
	input logic [pfs_pkg::ADDR_W-1:0] ADDR,
	input logic [pfs_pkg::DATA_W-1:0] WDATA,
	input logic WR,
	input logic RD,
	output logic [pfs_pkg::DATA_W-1:0] RDATA,
	input logic [pfs_pkg::NUM_E_PINS-1:0] PE_PIN_IN,
	output logic [pfs_pkg::NUM_E_PINS-1:0] PE_PIN_OUT,
	output logic [pfs_pkg::NUM_E_PINS-1:0] PE_PIN_OE,
	input logic [pfs_pkg::NUM_F_PINS-1:0] PF_PIN_IN,
	output logic [pfs_pkg::NUM_F_PINS-1:0] PF_PIN_OUT,
	output logic [pfs_pkg::NUM_F_PINS-1:0] PF_PIN_OE,
	input logic [pfs_pkg::NUM_E_PINS-1:0] PE_DOUT,
	output logic [pfs_pkg::NUM_E_PINS-1:0] PE_DIN,
	input logic [pfs_pkg::NUM_F_PINS-1:0] PF_DOUT,
	output logic [pfs_pkg::NUM_F_PINS-1:0] PF_DIN,
	input logic [13:6] TMR_OUT_E,
	input logic [5:3] TMR_ALT_OUT_E,
	output logic [5:0] TMR_CAP_IN_E,
	output logic [5:3] TMR_ALT_IN_E,
	input logic [3:0] TMR_BIDIR_OUT,
	input logic [3:0] TMR_BIDIR_OE,
	output logic [3:0] TMR_BIDIR_IN,
	input logic [pfs_pkg::NUM_F_PINS-1:0] TMR_CMP_OUT_F,
	output logic [13:0] TMR_IN_F,
	input logic CAN_TX,
	output logic CAN_RX,
	input logic SER_TX,
	output logic SER_RX
);
	import pfs_pkg::*;

	logic [DATA_W-1:0] pe_dir;
	logic [DATA_W-1:0] pe_upper;
	logic [DATA_W-1:0] pe_lower;
	logic [DATA_W-1:0] pe_alt;
	logic [DATA_W-1:0] pf_dir;
	logic [DATA_W-1:0] pf_upper;
	logic [DATA_W-1:0] pf_lower;
	logic [DATA_W-1:0] next_rdata;
	logic [NUM_E_PINS-1:0] e_sync;
	logic [NUM_F_PINS-1:0] f_sync;
	logic [NUM_E_PINS-1:0] e_port;
	logic [NUM_E_PINS-1:0] e_fn_oe;
	logic [NUM_E_PINS-1:0] e_fn_out;
	logic [NUM_F_PINS-1:0] f_port;
	logic [NUM_F_PINS-1:0] f_fn_oe;
	logic [NUM_F_PINS-1:0] f_fn_out;
	logic [2*DATA_W-1:0] pf_sel;

	// two-bit select code of port F pin n, upper register holds pins 15..8
	function automatic logic [1:0] field2(input logic [2*DATA_W-1:0] regs, input int n);
		return regs[2*n +: 2];
	endfunction

	assign pf_sel = {pf_upper, pf_lower};

	// register writes; masks keep reserved bits at zero whatever software sends
	// no sleep input: the registers simply hold, nothing but NRST clears them
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pe_dir <= REG_RESET;
			pe_upper <= REG_RESET;
			pe_lower <= REG_RESET;
			pe_alt <= REG_RESET;
			pf_dir <= REG_RESET;
			pf_upper <= REG_RESET;
			pf_lower <= REG_RESET;
		end
		else if (WR)
		begin
			case (ADDR)
				OFS_PE_DIR: pe_dir <= WDATA & MASK_PE_DIR;
				OFS_PE_UPPER: pe_upper <= WDATA & MASK_PE_UPPER;
				OFS_PE_LOWER: pe_lower <= WDATA & MASK_PE_LOWER;
				OFS_PE_ALT: pe_alt <= WDATA & MASK_PE_ALT;
				OFS_PF_DIR: pf_dir <= WDATA & MASK_PF_DIR;
				OFS_PF_UPPER: pf_upper <= WDATA & MASK_PF_SEL;
				OFS_PF_LOWER: pf_lower <= WDATA & MASK_PF_SEL;
				default: ;
			endcase
		end
	end

	always_comb
	begin
		case (ADDR)
			OFS_PE_DIR: next_rdata = pe_dir;
			OFS_PE_UPPER: next_rdata = pe_upper;
			OFS_PE_LOWER: next_rdata = pe_lower;
			OFS_PE_ALT: next_rdata = pe_alt;
			OFS_PF_DIR: next_rdata = pf_dir;
			OFS_PF_UPPER: next_rdata = pf_upper;
			OFS_PF_LOWER: next_rdata = pf_lower;
			default: next_rdata = RDATA_IDLE;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			RDATA <= RDATA_IDLE;
		else if (RD)
			RDATA <= next_rdata;
		else
			RDATA <= RDATA_IDLE;
	end

	pfs_sync #(
		.WIDTH(NUM_E_PINS)
	) u_e_sync (
		.clk(CLK),
		.nrst(NRST),
		.async_in(PE_PIN_IN),
		.level(e_sync)
	);

	pfs_sync #(
		.WIDTH(NUM_F_PINS)
	) u_f_sync (
		.clk(CLK),
		.nrst(NRST),
		.async_in(PF_PIN_IN),
		.level(f_sync)
	);

	// port E decode; a prohibited code leaves the pin released and out of port use
	always_comb
	begin
		e_port = '0;
		e_fn_oe = '0;
		e_fn_out = '0;
		for (int i = PE_UPPER_BASE; i < NUM_E_PINS; i++)
		begin
			e_port[i] = !pe_upper[PE_SINGLE_STEP*(i-PE_UPPER_BASE)];
			e_fn_oe[i] = pe_upper[PE_SINGLE_STEP*(i-PE_UPPER_BASE)];
			e_fn_out[i] = TMR_OUT_E[i];
		end
		case (pe_lower[PE7_LSB +: 2])
			CODE_PORT: e_port[7] = 1'b1;
			CODE_A:
			begin
				e_fn_oe[7] = 1'b1;
				e_fn_out[7] = TMR_OUT_E[7];
			end
			default: ;
		endcase
		case (pe_lower[PE6_LSB +: 2])
			CODE_PORT: e_port[6] = 1'b1;
			CODE_A:
			begin
				e_fn_oe[6] = 1'b1;
				e_fn_out[6] = TMR_OUT_E[6];
			end
			CODE_B:
			begin
				e_fn_oe[6] = 1'b1;
				e_fn_out[6] = CAN_TX;
			end
			default: ;
		endcase
		for (int i = 3; i < 6; i++)
		begin
			// primary capture bit set: input only, alternate field ignored
			if (!pe_lower[PE_SINGLE_STEP*i])
			begin
				case (pe_alt[PE_SINGLE_STEP*i +: 2])
					CODE_PORT: e_port[i] = 1'b1;
					CODE_A:
					begin
						e_fn_oe[i] = 1'b1;
						e_fn_out[i] = TMR_ALT_OUT_E[i];
					end
					default: ;
				endcase
			end
		end
		for (int p = 1; p < 3; p++)
		begin
			case (pe_lower[PE_SINGLE_STEP*p +: 2])
				CODE_PORT: e_port[p] = 1'b1;
				CODE_B:
				begin
					e_fn_oe[p] = TMR_BIDIR_OE[2*(2-p)];
					e_fn_out[p] = TMR_BIDIR_OUT[2*(2-p)];
				end
				CODE_C:
				begin
					e_fn_oe[p] = TMR_BIDIR_OE[2*(2-p)+1];
					e_fn_out[p] = TMR_BIDIR_OUT[2*(2-p)+1];
				end
				default: ;
			endcase
		end
		e_port[0] = !pe_lower[PE0_BIT];
	end

	// port F decode; code 10 on pins 13..0 is prohibited and releases the pin
	always_comb
	begin
		f_port = '0;
		f_fn_oe = '0;
		f_fn_out = '0;
		for (int i = 0; i < NUM_F_PINS; i++)
		begin
			f_port[i] = field2(pf_sel, i) == CODE_PORT;
			f_fn_oe[i] = field2(pf_sel, i) == CODE_A;
			f_fn_out[i] = TMR_CMP_OUT_F[i];
		end
		case (field2(pf_sel, 14))
			CODE_B:
			begin
				f_fn_oe[14] = 1'b1;
				f_fn_out[14] = CAN_TX;
			end
			CODE_C:
			begin
				f_fn_oe[14] = 1'b1;
				f_fn_out[14] = SER_TX;
			end
			default: ;
		endcase
	end

	for (genvar g = 0; g < NUM_E_PINS; g++)
	begin : g_e_pin
		pfs_pin_cell u_cell (
			.clk(CLK),
			.nrst(NRST),
			.port_mode(e_port[g]),
			.dir(pe_dir[g]),
			.port_dout(PE_DOUT[g]),
			.fn_oe(e_fn_oe[g]),
			.fn_out(e_fn_out[g]),
			.pin_level(e_sync[g]),
			.pad_out(PE_PIN_OUT[g]),
			.pad_oe(PE_PIN_OE[g]),
			.port_din(PE_DIN[g])
		);
	end

	for (genvar g = 0; g < NUM_F_PINS; g++)
	begin : g_f_pin
		pfs_pin_cell u_cell (
			.clk(CLK),
			.nrst(NRST),
			.port_mode(f_port[g]),
			.dir(pf_dir[g]),
			.port_dout(PF_DOUT[g]),
			.fn_oe(f_fn_oe[g]),
			.fn_out(f_fn_out[g]),
			.pin_level(f_sync[g]),
			.pad_out(PF_PIN_OUT[g]),
			.pad_oe(PF_PIN_OE[g]),
			.port_din(PF_DIN[g])
		);
	end

	// peripheral inputs: unselected timer inputs idle low, CAN and serial idle high
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			TMR_CAP_IN_E <= '0;
			TMR_ALT_IN_E <= '0;
			TMR_BIDIR_IN <= '0;
			TMR_IN_F <= '0;
			CAN_RX <= 1'b1;
			SER_RX <= 1'b1;
		end
		else
		begin
			for (int i = 3; i < 6; i++)
			begin
				TMR_CAP_IN_E[i] <= pe_lower[PE_SINGLE_STEP*i] & e_sync[i];
				TMR_ALT_IN_E[i] <= !pe_lower[PE_SINGLE_STEP*i]
					&& pe_alt[PE_SINGLE_STEP*i +: 2] == CODE_B && e_sync[i];
			end
			TMR_CAP_IN_E[2] <= pe_lower[PE2_LSB +: 2] == CODE_A && e_sync[2];
			TMR_CAP_IN_E[1] <= pe_lower[PE1_LSB +: 2] == CODE_A && e_sync[1];
			TMR_CAP_IN_E[0] <= pe_lower[PE0_BIT] & e_sync[0];
			TMR_BIDIR_IN[0] <= pe_lower[PE2_LSB +: 2] == CODE_B && e_sync[2];
			TMR_BIDIR_IN[1] <= pe_lower[PE2_LSB +: 2] == CODE_C && e_sync[2];
			TMR_BIDIR_IN[2] <= pe_lower[PE1_LSB +: 2] == CODE_B && e_sync[1];
			TMR_BIDIR_IN[3] <= pe_lower[PE1_LSB +: 2] == CODE_C && e_sync[1];
			for (int i = 0; i < 14; i++)
				TMR_IN_F[i] <= field2(pf_sel, i) == CODE_C && f_sync[i];
			// both ports may offer CAN receive; port E wins if both are selected
			if (pe_lower[PE7_LSB +: 2] == CODE_B)
				CAN_RX <= e_sync[7];
			else if (field2(pf_sel, 15) == CODE_B)
				CAN_RX <= f_sync[15];
			else
				CAN_RX <= 1'b1;
			SER_RX <= (field2(pf_sel, 15) == CODE_C) ? f_sync[15] : 1'b1;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	reset_clear_a: assert property (!$past(NRST) |->
		(pe_dir | pe_upper | pe_lower | pe_alt | pf_dir | pf_upper | pf_lower) == REG_RESET)
		else $error("select registers not clear after reset");
	unmapped_read_a: assert property ((RD && ADDR > OFS_PF_LOWER) |=> RDATA == RDATA_IDLE)
		else $error("unmapped read returned nonzero data");
	reserved_read_a: assert property ((WR && ADDR == OFS_PE_LOWER) ##1
		(RD && !WR && ADDR == OFS_PE_LOWER) |=> RDATA == ($past(WDATA, 2) & MASK_PE_LOWER))
		else $error("lower select readback does not match masked write");
	e13_timer_a: assert property (pe_upper[10] |=>
		PE_PIN_OE[13] && PE_PIN_OUT[13] == $past(TMR_OUT_E[13]))
		else $error("pin e13 not driven by timer output");
	e7_can_rx_a: assert property ((pe_lower[15:14] == CODE_B) |=>
		!PE_PIN_OE[7] && CAN_RX == $past(e_sync[7]))
		else $error("pin e7 not routed to CAN receive");
	alt_blocked_a: assert property (pe_lower[10] |=> !TMR_ALT_IN_E[5] && !PE_PIN_OE[5])
		else $error("alternate select acted while primary bit set");
	f0_port_out_a: assert property ((pf_lower[1:0] == CODE_PORT && pf_dir[0]) |=>
		PF_PIN_OE[0] && PF_PIN_OUT[0] == $past(PF_DOUT[0]))
		else $error("port f pin 0 output does not follow port data");
	f0_dir_ignored_a: assert property ((pf_lower[1:0] == CODE_C) |=>
		!PF_PIN_OE[0] && TMR_IN_F[0] == $past(f_sync[0]))
		else $error("direction bit influenced a timer input pin");
	f14_serial_a: assert property ((pf_upper[13:12] == CODE_C) |=>
		PF_PIN_OE[14] && PF_PIN_OUT[14] == $past(SER_TX))
		else $error("pin f14 not driven by serial transmit");
	e0_input_a: assert property ((!pe_lower[0] && !pe_dir[0]) |=>
		!PE_PIN_OE[0] && PE_DIN[0] == $past(e_sync[0]))
		else $error("port e pin 0 input path wrong");

	can_tx_c: cover property (pe_lower[13:12] == CODE_B ##1 PE_PIN_OE[6]);
	serial_rx_c: cover property (pf_upper[15:14] == CODE_C ##2 !SER_RX);
	bidir_c: cover property (pe_lower[3:2] == CODE_C && TMR_BIDIR_OE[3] ##1 PE_PIN_OE[1]);
endmodule

// ---- dv/pfs_periph_model.sv ----
// far-end stand-in for the timer, CAN and serial units behind the pins
// assumes it shares the block's clock; the bench picks the output pattern
`timescale 1ns/1ps
module pfs_periph_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] pat,
	output logic [13:6] tmr_out_e,
	output logic [5:3] tmr_alt_out_e,
	output logic [3:0] bidir_out,
	output logic [3:0] bidir_oe,
	output logic [15:0] cmp_out_f,
	output logic can_tx,
	output logic ser_tx
);
	// launched from flops as real peripherals are, so pads see them a cycle late
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tmr_out_e <= '0;
			tmr_alt_out_e <= '0;
			bidir_out <= '0;
			bidir_oe <= '0;
			cmp_out_f <= '0;
			can_tx <= 1'b1;
			ser_tx <= 1'b1;
		end
		else
		begin
			tmr_out_e <= pat[13:6];
			tmr_alt_out_e <= pat[5:3];
			bidir_out <= pat[3:0];
			bidir_oe <= 4'hF;
			cmp_out_f <= ~pat;
			can_tx <= pat[0];
			ser_tx <= pat[1];
		end
	end
endmodule

// ---- dv/pfs_pin_function_select_tb.sv ----
// self-checking bench for the port E / port F pin function select block
// assumes the register offsets of the package and a board that drives undriven pads
`timescale 1ns/1ps
module pfs_pin_function_select_tb;
	import pfs_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [15:0] pat = 16'hA5E9;
	logic [13:0] pe_ext = 14'h2A5C;
	logic [13:0] pe_dout = '0;
	logic [15:0] pf_ext = 16'h9C63;
	logic [15:0] pf_dout = '0;
	logic [15:0] rdata, pf_out, pf_oe, pf_din, pf_pin, cmp;
	logic [13:0] pe_out, pe_oe, pe_din, pe_pin, tin_f;
	logic [13:6] tout_e;
	logic [5:3] aout_e, ain_e;
	logic [5:0] cap_e;
	logic [3:0] b_out, b_oe, b_in;
	logic can_tx, can_rx, ser_tx, ser_rx;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;

	// pad level: the enabled driver wins, the board holds the rest
	assign pe_pin = (pe_oe & pe_out) | (~pe_oe & pe_ext);
	assign pf_pin = (pf_oe & pf_out) | (~pf_oe & pf_ext);

	always #2.5 clk = ~clk;

	pfs_pin_function_select dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .PE_PIN_IN(pe_pin), .PE_PIN_OUT(pe_out),
		.PE_PIN_OE(pe_oe), .PF_PIN_IN(pf_pin), .PF_PIN_OUT(pf_out), .PF_PIN_OE(pf_oe),
		.PE_DOUT(pe_dout), .PE_DIN(pe_din), .PF_DOUT(pf_dout), .PF_DIN(pf_din),
		.TMR_OUT_E(tout_e), .TMR_ALT_OUT_E(aout_e), .TMR_CAP_IN_E(cap_e),
		.TMR_ALT_IN_E(ain_e), .TMR_BIDIR_OUT(b_out), .TMR_BIDIR_OE(b_oe),
		.TMR_BIDIR_IN(b_in), .TMR_CMP_OUT_F(cmp), .TMR_IN_F(tin_f), .CAN_TX(can_tx),
		.CAN_RX(can_rx), .SER_TX(ser_tx), .SER_RX(ser_rx));

	pfs_periph_model periph_u (.clk(clk), .nrst(nrst), .pat(pat), .tmr_out_e(tout_e),
		.tmr_alt_out_e(aout_e), .bidir_out(b_out), .bidir_oe(b_oe), .cmp_out_f(cmp),
		.can_tx(can_tx), .ser_tx(ser_tx));

	task automatic complete_run();
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d; // callers outside t_mask keep reserved bits zero, no prohibited codes
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// write strobe directly followed by a read strobe of the same register
	task automatic wr_rchk(input string nm, input logic [3:0] a, input logic [15:0] d,
		input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, e);
	endtask

	task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, e);
	endtask

	// covers the pin synchroniser plus the pad flop, with margin
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		for (int i = 0; i < 7; i++)
			rchk("reset_reg", 4'(2 * i), 16'h0000);
		chk("reset_oe", 16'(pe_oe), 16'h0000);
		chk("reset_rx", {14'h0, can_rx, ser_rx}, 16'h0003);
	endtask

	task automatic t_mask();
		logic [15:0] msk [7];
		msk = '{16'h3FFF, 16'h0555, 16'hF57D, 16'h0FC0, 16'hFFFF, 16'hFFFF, 16'hFFFF};
		for (int i = 0; i < 7; i++)
		begin
			wr_reg(4'(2 * i), 16'hFFFF);
			rchk("mask", 4'(2 * i), msk[i]);
			wr_reg(4'(2 * i), 16'h0000);
		end
		// further writes that set reserved bits, at an unmapped offset and back to back, to prove they are dropped
		wr_reg(4'hE, 16'hFFFF);
		rchk("unmapped", 4'hE, 16'h0000);
		wr_rchk("lower_b2b", OFS_PE_LOWER, 16'hAAAA, 16'hAAAA & MASK_PE_LOWER);
		wr_reg(OFS_PE_LOWER, 16'h0000);
	endtask

	task automatic t_port();
		@(posedge clk);
		pe_dout <= 14'h3FFF;
		pf_dout <= 16'hF0F0;
		wr_reg(OFS_PE_DIR, 16'h1555);
		wr_reg(OFS_PF_DIR, 16'h5555);
		@(posedge clk);
		pf_ext <= 16'h639C;
		settle();
		chk("e_oe", 16'(pe_oe), 16'h1555);
		chk("e_out", 16'(pe_out), 16'h1555);
		chk("e_din", 16'(pe_din), 16'h1555 | (16'h2AAA & 16'(pe_ext)));
		chk("f_oe", pf_oe, 16'h5555);
		chk("f_out", pf_out, 16'h5050);
		chk("f_din", pf_din, 16'h5050 | (16'hAAAA & pf_ext));
	endtask

	task automatic t_e_upper();
		wr_reg(OFS_PE_UPPER, 16'h0555);
		settle();
		chk("e_up_oe", 16'(pe_oe[13:8]), 16'h003F);
		chk("e_up_out", 16'(pe_out[13:8]), 16'h0025);
		chk("e_up_din", 16'(pe_din[13:8]), 16'h0000);
		wr_reg(OFS_PE_UPPER, 16'h0400);
		settle();
		chk("e13_oe", 16'(pe_oe[13:8]), 16'h0035);
		chk("e13_out", 16'(pe_out[13:8]), 16'h0035);
		wr_reg(OFS_PE_UPPER, 16'h0000);
	endtask

	task automatic t_e_lower();
		wr_reg(OFS_PE_LOWER, 16'h5000);
		settle();
		chk("e76_tmr", {pe_oe[7:6], pe_out[7:6]}, 16'h000F);
		wr_reg(OFS_PE_LOWER, 16'hA000);
		settle();
		chk("e76_can", {can_rx, pe_oe[7:6], pe_out[6]}, 16'h0003);
		wr_reg(OFS_PE_LOWER, 16'h0555);
		settle();
		chk("e_cap", {pe_oe[5:0], 2'b00, cap_e}, 16'h001C);
		wr_reg(OFS_PE_LOWER, 16'h0028);
		settle();
		chk("e21_b10", {pe_oe[2:1], pe_out[2:1], b_in}, 16'h00E1);
		wr_reg(OFS_PE_LOWER, 16'h003C);
		settle();
		chk("e21_b11", {pe_oe[2:1], pe_out[2:1], b_in}, 16'h00D8);
		wr_reg(OFS_PE_LOWER, 16'h0000);
	endtask

	task automatic t_e_alt();
		wr_reg(OFS_PE_ALT, 16'h0540);
		settle();
		chk("alt_out", {pe_oe[5:3], pe_out[5:3]}, 16'h003D);
		wr_reg(OFS_PE_ALT, 16'h0A80);
		settle();
		chk("alt_in", {pe_oe[5:3], ain_e}, 16'h0003);
		wr_reg(OFS_PE_ALT, 16'h0540);
		wr_reg(OFS_PE_LOWER, 16'h0100);
		settle();
		chk("alt_gate", {pe_oe[5:3], cap_e[4]}, 16'h000B);
		wr_reg(OFS_PE_LOWER, 16'h0000);
		wr_reg(OFS_PE_ALT, 16'h0000);
	endtask

	task automatic t_f();
		wr_reg(OFS_PF_UPPER, 16'h5555);
		wr_reg(OFS_PF_LOWER, 16'h5555);
		settle();
		chk("f_cmp_oe", pf_oe, 16'hFFFF);
		chk("f_cmp_out", pf_out, 16'h5A16);
		wr_reg(OFS_PF_UPPER, 16'hA000);
		wr_reg(OFS_PF_LOWER, 16'h0000);
		settle();
		chk("f_can_oe", pf_oe, 16'h5555);
		chk("f_can", {can_rx, pf_out[14]}, 16'h0001);
		wr_reg(OFS_PF_UPPER, 16'hFFFF);
		wr_reg(OFS_PF_LOWER, 16'hFFFF);
		settle();
		chk("f_ser_oe", pf_oe, 16'h4000);
		chk("f_ser", {ser_rx, pf_out[14]}, 16'h0000);
		chk("f_tin", 16'(tin_f), 16'h239C);
	endtask

	task automatic t_sleep();
		repeat (50) @(posedge clk);
		rchk("hold", OFS_PF_DIR, 16'h5555);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rchk("rereset", OFS_PF_UPPER, 16'h0000);
		rchk("rereset_dir", OFS_PF_DIR, 16'h0000);
	endtask

	// cut a hang well past the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			complete_run();
		end
	end

	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_mask();
		t_port();
		t_e_upper();
		t_e_lower();
		t_e_alt();
		t_f();
		t_sleep();
		complete_run();
	end
endmodule
